// File: verilog/apfs_top.sv
// Purpose: per-pin function select of the eight-bit analog port
// Assumes: bus and pin inputs synchronous to MCLK
// Notes:   pin controls lag a register write by one cycle
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "apfs_defines.svh"
module apfs_top #(
    parameter int unsigned NPIN = 8
) (
    input  wire logic              MCLK,
    input  wire logic              RESET_N,
    input  wire logic              CE,
    input  wire logic [7:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    input  wire logic [NPIN-1:0]   PIN_IN,
    output logic      [7:0]        RDATA,
    output logic      [NPIN-1:0]   PIN_OUT,
    output logic      [NPIN-1:0]   PIN_OE,
    output logic      [NPIN-1:0]   PIN_IE,
    output logic      [NPIN-1:0]   PIN_ANALOG,
    output logic      [NPIN-1:0]   CONV_ROUTE,
    output logic      [NPIN-1:0]   AMP_IN_CONNECT,
    output logic      [NPIN-1:0]   AMP_OUT_CONNECT,
    output logic                   AMPA_ON,
    output logic                   AMPB_ON,
    output logic      [2:0]        CONV_CHANNEL,
    output logic      [NPIN-1:0]   SETTING_BAD
);

    typedef struct packed {
        logic [NPIN-1:0] latch;
        logic [NPIN-1:0] dir;
        logic [NPIN-1:0] analog;
        logic [2:0]      chsel;
        logic            ampa_en;
        logic            ampb_en;
        logic [7:0]      rdata;
        logic [NPIN-1:0] pin_out;
        logic [NPIN-1:0] pin_oe;
        logic [NPIN-1:0] pin_ie;
        logic [NPIN-1:0] pin_analog;
        logic [NPIN-1:0] conv;
        logic [NPIN-1:0] amp_in;
        logic [NPIN-1:0] amp_out;
        logic [NPIN-1:0] bad;
    } apfs_state_t;

    apfs_state_t            st_ff;
    apfs_state_t            nxt_st;
    apfs_pkg::apfs_bus_t    bus;
    apfs_pkg::apfs_pinfn_t  fn     [NPIN];
    logic [NPIN-1:0]        port_rd;

    assign bus.addr  = ADDR;
    assign bus.wdata = WDATA;
    assign bus.wr    = WR;
    assign bus.rd    = RD;

    // pin roles: 0..2 amplifier A, 3..4 plain, 5..7 amplifier B
    generate
        for (genvar i = 0; i < NPIN; i++) begin : g_pin
            localparam apfs_pkg::apfs_role_t ROLE =
                (i == 0 || i == 2) ? apfs_pkg::APFS_AMPA_IN  :
                (i == 1)           ? apfs_pkg::APFS_AMPA_OUT :
                (i == 5 || i == 7) ? apfs_pkg::APFS_AMPB_IN  :
                (i == 6)           ? apfs_pkg::APFS_AMPB_OUT :
                                     apfs_pkg::APFS_PLAIN;
            localparam logic [2:0] CHAN = 3'(i);
            logic amp_en;

            assign amp_en = (i <= 2) ? st_ff.ampa_en :
                            (i >= 5) ? st_ff.ampb_en : 1'b0;

            apfs_pin_cell #(
                .ROLE (ROLE)
            ) u_cell (
                .analog  (st_ff.analog[i]),
                .dir_in  (st_ff.dir[i]),
                .sel_hit (st_ff.chsel == CHAN),
                .amp_en  (amp_en),
                .fn      (fn[i])
            );

            // analog pins read zero, outputs read back the latch
            assign port_rd[i] = st_ff.analog[i] ? 1'b0 :
                                st_ff.dir[i]    ? PIN_IN[i] :
                                                  st_ff.latch[i];
        end
    endgenerate

    always_comb begin
        nxt_st = st_ff;
        if (CE) begin
            // register writes; unmapped addresses are ignored
            if (bus.wr) begin
                if (bus.addr == `APFS_OFF_PORT) begin
                    nxt_st.latch = bus.wdata[NPIN-1:0];
                end else if (bus.addr == `APFS_OFF_DIR) begin
                    nxt_st.dir = bus.wdata[NPIN-1:0];
                end else if (bus.addr == `APFS_OFF_ANALOG) begin
                    nxt_st.analog = bus.wdata[NPIN-1:0];
                end else if (bus.addr == `APFS_OFF_CHSEL) begin
                    nxt_st.chsel = bus.wdata[2:0];
                end else if (bus.addr == `APFS_OFF_AMPCTL) begin
                    nxt_st.ampa_en = bus.wdata[`APFS_BIT_AMPA_EN];
                    nxt_st.ampb_en = bus.wdata[`APFS_BIT_AMPB_EN];
                end
            end

            // read data valid only in the cycle after the strobe
            nxt_st.rdata = 8'h00;
            if (bus.rd) begin
                if (bus.addr == `APFS_OFF_PORT) begin
                    nxt_st.rdata = port_rd;
                end else if (bus.addr == `APFS_OFF_DIR) begin
                    nxt_st.rdata = st_ff.dir;
                end else if (bus.addr == `APFS_OFF_ANALOG) begin
                    nxt_st.rdata = st_ff.analog;
                end else if (bus.addr == `APFS_OFF_CHSEL) begin
                    nxt_st.rdata = {5'h00, st_ff.chsel};
                end else if (bus.addr == `APFS_OFF_AMPCTL) begin
                    nxt_st.rdata[`APFS_BIT_AMPA_EN] = st_ff.ampa_en;
                    nxt_st.rdata[`APFS_BIT_AMPB_EN] = st_ff.ampb_en;
                end else if (bus.addr == `APFS_OFF_STATUS) begin
                    nxt_st.rdata = st_ff.bad;
                end
            end

            // pin controls follow the configuration one cycle later
            for (int i = 0; i < NPIN; i++) begin
                nxt_st.pin_out[i]    = st_ff.latch[i];
                nxt_st.pin_oe[i]     = fn[i].drive;
                nxt_st.pin_ie[i]     = fn[i].dig_in;
                nxt_st.pin_analog[i] = fn[i].analog;
                nxt_st.conv[i]       = fn[i].conv;
                nxt_st.amp_in[i]     = fn[i].amp_in;
                nxt_st.amp_out[i]    = fn[i].amp_out;
                nxt_st.bad[i]        = fn[i].bad;
            end
        end
    end

    // reset puts every pin in analog input, amplifiers off
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff            <= '0;
            st_ff.latch      <= `APFS_RST_LATCH;
            st_ff.dir        <= `APFS_RST_DIR;
            st_ff.analog     <= `APFS_RST_ANALOG;
            st_ff.chsel      <= `APFS_RST_CHSEL;
            st_ff.pin_analog <= `APFS_RST_ANALOG;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RDATA           = st_ff.rdata;
    assign PIN_OUT         = st_ff.pin_out;
    assign PIN_OE          = st_ff.pin_oe;
    assign PIN_IE          = st_ff.pin_ie;
    assign PIN_ANALOG      = st_ff.pin_analog;
    assign CONV_ROUTE      = st_ff.conv;
    assign AMP_IN_CONNECT  = st_ff.amp_in;
    assign AMP_OUT_CONNECT = st_ff.amp_out;
    assign AMPA_ON         = st_ff.ampa_en;
    assign AMPB_ON         = st_ff.ampb_en;
    assign CONV_CHANNEL    = st_ff.chsel;
    assign SETTING_BAD     = st_ff.bad;

endmodule : apfs_top

// File: pkg/apfs_defines.svh
// Purpose: constants of the analog port pin function select block
// Assumes: 8-bit register port, one register per address
// Notes:   reset values put every pin in analog input
// Contract
// - port has output latch and one direction bit per pin
// - any reset leaves every pin as analog input
// - analog input pin selected by channel select goes to converter
// - analog input pin not selected stays analog, unconverted
// - amplifier A input pins feed amplifier A, convert when selected
// - amplifier A output pin shows amplifier output, converts when selected
// - amplifier B inputs go to amplifier when enabled, else converter
// - amplifier B output pin drives amplifier when enabled, else converted
// - amplifier A enable sits in control bit 7
// - amplifier B enable sits in control bit 3
`ifndef APFS_DEFINES_SVH
`define APFS_DEFINES_SVH

`define APFS_OFF_PORT     8'h00
`define APFS_OFF_DIR      8'h01
`define APFS_OFF_ANALOG   8'h02
`define APFS_OFF_CHSEL    8'h03
`define APFS_OFF_AMPCTL   8'h04
`define APFS_OFF_STATUS   8'h05

`define APFS_BIT_AMPA_EN  7
`define APFS_BIT_AMPB_EN  3

`define APFS_RST_LATCH    8'h00
`define APFS_RST_DIR      8'hff
`define APFS_RST_ANALOG   8'hff
`define APFS_RST_CHSEL    3'h0

`endif

// File: pkg/apfs_pkg.sv
// Purpose: types of the analog port pin function select block
// Assumes: eight pins, fixed role per pin
// Notes:   roles are one-hot coded
package apfs_pkg;

    typedef enum logic [4:0] {
        APFS_PLAIN    = 5'h01,
        APFS_AMPA_IN  = 5'h02,
        APFS_AMPA_OUT = 5'h04,
        APFS_AMPB_IN  = 5'h08,
        APFS_AMPB_OUT = 5'h10
    } apfs_role_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } apfs_bus_t;

    typedef struct packed {
        logic drive;
        logic dig_in;
        logic analog;
        logic conv;
        logic amp_in;
        logic amp_out;
        logic bad;
    } apfs_pinfn_t;

endpackage : apfs_pkg

// File: verilog/apfs_pin_cell.sv
// Purpose: function decode of one analog-capable port pin
// Assumes: role fixed at elaboration
// Notes:   purely combinational; the top registers the result
`timescale 1ns/1ps
module apfs_pin_cell #(
    parameter apfs_pkg::apfs_role_t ROLE = apfs_pkg::APFS_PLAIN
) (
    input  wire logic                  analog,
    input  wire logic                  dir_in,
    input  wire logic                  sel_hit,
    input  wire logic                  amp_en,
    output apfs_pkg::apfs_pinfn_t      fn
);
    logic ana_in;
    logic is_a;
    logic is_b;
    logic is_out;
    logic is_in;

    always_comb begin
        ana_in = analog & dir_in;
        is_a   = (ROLE == apfs_pkg::APFS_AMPA_IN)
               | (ROLE == apfs_pkg::APFS_AMPA_OUT);
        is_b   = (ROLE == apfs_pkg::APFS_AMPB_IN)
               | (ROLE == apfs_pkg::APFS_AMPB_OUT);
        is_out = (ROLE == apfs_pkg::APFS_AMPA_OUT)
               | (ROLE == apfs_pkg::APFS_AMPB_OUT);
        is_in  = (ROLE == apfs_pkg::APFS_AMPA_IN)
               | (ROLE == apfs_pkg::APFS_AMPB_IN);
        fn.analog  = analog;
        fn.dig_in  = ~analog;
        // amplifier A output pin never takes the latch while amplifier A is enabled
        fn.drive   = ~analog & ~dir_in & ~(is_out & is_a & amp_en);
        // amplifier B enabled takes its pins off the converter
        fn.conv    = ana_in & sel_hit & ~(is_b & amp_en);
        fn.amp_in  = ana_in & is_in & amp_en;
        fn.amp_out = ana_in & is_out & amp_en;
        fn.bad     = (analog & ~dir_in)
                   | (~analog & sel_hit & ~is_b)
                   | (~analog & amp_en & is_out & is_a);
    end
endmodule : apfs_pin_cell

// File: tb/apfs_chk.sv
// Purpose: port checks of the analog port pin function select
// Assumes: NPIN of 8, pin outputs registered from one config
// Notes:   relates registered outputs to each other and to the CE and RD strobes
`timescale 1ns/1ps
module apfs_chk #(
    parameter int unsigned NPIN = 8
) (
    input wire logic            MCLK,
    input wire logic            RESET_N,
    input wire logic            CE,
    input wire logic            RD,
    input wire logic [7:0]      RDATA,
    input wire logic [NPIN-1:0] PIN_OE,
    input wire logic [NPIN-1:0] PIN_IE,
    input wire logic [NPIN-1:0] PIN_ANALOG,
    input wire logic [NPIN-1:0] CONV_ROUTE,
    input wire logic [NPIN-1:0] AMP_IN_CONNECT,
    input wire logic [NPIN-1:0] AMP_OUT_CONNECT
);
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RESET_N);
    AST_IE_ANALOG: assert property (
        PIN_IE == ~PIN_ANALOG) else $error("input path open on analog pin");
    AST_NO_DRIVE: assert property (
        (PIN_OE & PIN_ANALOG) == '0) else $error("analog pin driven");
    AST_CONV_ONE: assert property (
        $onehot0(CONV_ROUTE)) else $error("more than one pin converted");
    AST_CONV_ANALOG: assert property (
        (CONV_ROUTE & ~PIN_ANALOG) == '0) else $error("digital pin converted");
    AST_AMP_PINS: assert property (
        (AMP_IN_CONNECT[7:0] & 8'h5a) == 8'h00
        && (AMP_OUT_CONNECT[7:0] & 8'hbd) == 8'h00) else $error("amp on pin");
    AST_AMP_ANALOG: assert property (
        ((AMP_IN_CONNECT | AMP_OUT_CONNECT) & ~PIN_ANALOG) == '0)
        else $error("amplifier on digital pin");
    AST_AMPB_IN: assert property (
        !(AMP_IN_CONNECT[5] && CONV_ROUTE[5])
        && !(AMP_IN_CONNECT[7] && CONV_ROUTE[7])) else $error("b in converted");
    AST_AMPB_OUT: assert property (
        !(AMP_OUT_CONNECT[6] && CONV_ROUTE[6])) else $error("b out converted");
    AST_RST_ANALOG: assert property (
        disable iff (1'b0) !RESET_N |-> PIN_ANALOG == '1 && PIN_OE == '0)
        else $error("pins not analog in reset");
    AST_RD_IDLE: assert property (
        CE && !RD |=> RDATA == 8'h00) else $error("read data outside read");
    AST_CE_HOLD: assert property (
        !CE |=> $stable(PIN_OE) && $stable(PIN_ANALOG))
        else $error("pins moved with clock enable low");
endmodule : apfs_chk

bind apfs_top apfs_chk #(.NPIN(NPIN)) apfs_chk_i (.MCLK(MCLK),
    .RESET_N(RESET_N), .CE(CE), .RD(RD), .RDATA(RDATA), .PIN_OE(PIN_OE),
    .PIN_IE(PIN_IE), .PIN_ANALOG(PIN_ANALOG), .CONV_ROUTE(CONV_ROUTE),
    .AMP_IN_CONNECT(AMP_IN_CONNECT), .AMP_OUT_CONNECT(AMP_OUT_CONNECT));

// File: tb/apfs_top_tb.sv
// Purpose: register-level bench of the analog port pin function select
// Assumes: config reaches the pins within three edges of a write
// Notes:   expectations follow the per-pin function tables
`timescale 1ns/1ps
`include "apfs_defines.svh"
module apfs_top_tb;
    logic       mclk    = 1'b0;
    logic       reset_n = 1'b1;
    logic       ce      = 1'b1;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] addr    = 8'h00;
    logic [7:0] wdata   = 8'h00;
    logic [7:0] pin_in  = 8'hff;
    logic [7:0] rdata, pin_out, pin_oe, pin_ie, pin_an, conv, amp_in;
    logic [7:0] amp_out, bad;
    logic [2:0] conv_ch;
    logic       ampa_on, ampb_on;
    int         n_fail = 0;
    int         cmp_count = 0;
    int         cycles = 0;

    apfs_top #(.NPIN(8)) apfs_top_i (.MCLK(mclk), .RESET_N(reset_n),
        .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .PIN_IN(pin_in), .RDATA(rdata), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
        .PIN_IE(pin_ie), .PIN_ANALOG(pin_an), .CONV_ROUTE(conv),
        .AMP_IN_CONNECT(amp_in), .AMP_OUT_CONNECT(amp_out),
        .AMPA_ON(ampa_on), .AMPB_ON(ampb_on), .CONV_CHANNEL(conv_ch),
        .SETTING_BAD(bad));

    always #50 mclk = ~mclk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // a hung bench ends as a mismatch rather than running on
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wreg

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask : rreg

    task automatic cfg(input logic [7:0] an, input logic [7:0] dir,
                       input logic [7:0] ch, input logic [7:0] amp);
        wreg(`APFS_OFF_ANALOG, an);
        wreg(`APFS_OFF_DIR, dir);
        wreg(`APFS_OFF_CHSEL, ch);
        wreg(`APFS_OFF_AMPCTL, amp);
        repeat (3) @(posedge mclk);
        #1;
    endtask : cfg

    initial begin
        // falling edge at time zero fires the async reset before any edge
        reset_n <= 1'b0;
        repeat (10) @(posedge mclk);
        #1;
        chk("analog in reset", pin_an, 8'hff);
        @(posedge mclk);
        reset_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk("input enable", pin_ie, 8'h00);
        chk("conv route", conv, 8'h01);
        rreg(`APFS_OFF_DIR, 8'hff, "dir");
        rreg(`APFS_OFF_ANALOG, 8'hff, "analog");
        rreg(`APFS_OFF_PORT, 8'h00, "port");
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            cfg(8'hff, 8'hff, 8'(c), 8'h00);
            chk("conv route", conv, 8'h01 << c);
            chk("channel", {5'h00, conv_ch}, 8'(c));
        end
        $display("test channels done");
        pin_in <= 8'h3c;
        wreg(`APFS_OFF_PORT, 8'ha5);
        cfg(8'h00, 8'h0f, 8'h07, 8'h00);
        chk("drive", pin_oe, 8'hf0);
        chk("latch", pin_out, 8'ha5);
        chk("bad", bad, 8'h00);
        rreg(`APFS_OFF_PORT, 8'hac, "port");
        cfg(8'hf0, 8'hff, 8'h07, 8'h00);
        rreg(`APFS_OFF_PORT, 8'h0c, "port");
        $display("test digital done");
        cfg(8'hff, 8'hff, 8'h00, 8'h88);
        chk("amp on", {6'h00, ampa_on, ampb_on}, 8'h03);
        chk("amp in", amp_in, 8'ha5);
        chk("amp out", amp_out, 8'h42);
        chk("conv route", conv, 8'h01);
        wreg(`APFS_OFF_AMPCTL, 8'hff);
        rreg(`APFS_OFF_AMPCTL, 8'h88, "ampctl");
        cfg(8'hff, 8'hff, 8'h01, 8'h88);
        chk("conv route", conv, 8'h02);
        cfg(8'hff, 8'hff, 8'h06, 8'h88);
        chk("conv route", conv, 8'h00);
        cfg(8'hff, 8'hff, 8'h05, 8'h88);
        chk("conv route", conv, 8'h00);
        cfg(8'hff, 8'hff, 8'h07, 8'h80);
        chk("amp in", amp_in, 8'h05);
        chk("amp out", amp_out, 8'h02);
        chk("conv route", conv, 8'h80);
        $display("test amplifiers done");
        cfg(8'hfe, 8'hfe, 8'h00, 8'h00);
        rreg(`APFS_OFF_STATUS, 8'h01, "status");
        cfg(8'hff, 8'h7f, 8'h07, 8'h00);
        chk("bad", bad, 8'h80);
        cfg(8'hfd, 8'hfd, 8'h03, 8'h80);
        chk("bad", bad, 8'h02);
        chk("drive", pin_oe, 8'h00);
        wreg(8'h3f, 8'h55);
        rreg(8'h3f, 8'h00, "unmapped");
        wreg(`APFS_OFF_STATUS, 8'hff);
        rreg(`APFS_OFF_STATUS, 8'h02, "status");
        @(posedge mclk);
        ce <= 1'b0;
        wreg(`APFS_OFF_ANALOG, 8'h00);
        @(posedge mclk);
        ce <= 1'b1;
        rreg(`APFS_OFF_ANALOG, 8'hfd, "analog");
        $display("test refusals done");
        @(posedge mclk);
        reset_n <= 1'b0;
        @(posedge mclk);
        #1;
        chk("analog in reset", pin_an, 8'hff);
        @(posedge mclk);
        reset_n <= 1'b1;
        rreg(`APFS_OFF_DIR, 8'hff, "dir");
        $display("test second reset done");
        print_verdict();
    end
endmodule : apfs_top_tb
